// File: hdl/usb_host_clock_gating_clkrun.sv
// Clock gating decision and clock-run requester of the USB host controller.
// Assumes status levels from host cores are on clk_sys; the link line and PCI clock are pins.
`timescale 1ns/1ps
module usb_host_clock_gating_clkrun (
  input wire logic clk_sys,
  input wire logic nrst,
  clkrun_if.device link,
  input wire logic [7:0] extension_config_two,
  input wire logic ehci_stopped_flag,
  input wire logic [clkrun_pkg::NUM_PORTS-1:0] portSuspended,
  input wire logic [clkrun_pkg::NUM_PORTS-1:0] portEnabled,
  input wire logic [1:0] ohci_functional_state_a,
  input wire logic [1:0] ohci_functional_state_b,
  input wire logic aux_power_reset_input,
  input wire logic [2*clkrun_pkg::NUM_FUNCS-1:0] funcPowerState,
  input wire logic ohciActivity,
  input wire logic [2:0] ehciWakeEvent,
  input wire logic [2:0] ehciWakeEnable,
  input wire logic ohciBusMasterReq,
  input wire logic ehci_run_stop_bit,
  output logic useOscillator,
  output logic [1:0] stopLevel,
  output logic logicClkStop,
  output logic pllStop,
  output logic oscStop,
  output logic pciClkHeld
);
  typedef enum logic [1:0] {
    IDLE = 2'h0,
    DRIVE = 2'h1,
    WAITRUN = 2'h3
  } run_state_t;

  typedef struct packed {
    logic [2:0] clkSync;
    logic [2:0] lineSync;
    logic [2:0] auxSync;
    run_state_t state;
    logic [1:0] edgeCnt;
    logic [1:0] idleCnt;
    logic driveOe;
    logic useOsc;
    logic [1:0] level;
    logic [1:0] condPrev;
    logic held;
    logic logicStop;
    logic oscOff;
  } state_t;

  state_t s_r, s_nxt;
  logic baseOk;
  logic allD0;
  logic noneD0;
  logic [1:0] wantLevel;
  logic wake;
  logic needClk;
  logic clkRise;
  logic lineHigh;
  int i;

  always_comb begin
    s_nxt = s_r;
    baseOk = ehci_stopped_flag;
    if (&(portSuspended | ~portEnabled) == 1'b0) begin
      baseOk = 1'b0;
    end
    if (!((ohci_functional_state_a == clkrun_pkg::FUNC_STATE_SUSPEND ||
           ohci_functional_state_a == clkrun_pkg::FUNC_STATE_RESET) &&
          (ohci_functional_state_b == clkrun_pkg::FUNC_STATE_SUSPEND ||
           ohci_functional_state_b == clkrun_pkg::FUNC_STATE_RESET))) begin
      baseOk = 1'b0;
    end
    allD0 = 1'b1;
    noneD0 = 1'b1;
    for (i = 0; i < clkrun_pkg::NUM_FUNCS; i++) begin
      if (funcPowerState[2*i +: 2] == clkrun_pkg::PWR_STATE_D0) begin
        noneD0 = 1'b0;
      end else begin
        allD0 = 1'b0;
      end
    end
    // Synchronised aux input so a glitch cannot stop the oscillator
    s_nxt.auxSync = {s_r.auxSync[1:0], aux_power_reset_input};
    wantLevel = clkrun_pkg::STOP_NONE;
    if (baseOk && s_r.auxSync[2] == s_r.auxSync[1]) begin
      if (s_r.auxSync[2] && allD0) begin
        wantLevel = clkrun_pkg::STOP_LOGIC;
      end else if (s_r.auxSync[2] && noneD0) begin
        wantLevel = clkrun_pkg::STOP_PLL;
      end else if (!s_r.auxSync[2] && noneD0) begin
        wantLevel = clkrun_pkg::STOP_OSC;
      end
    end
    wake = ohciActivity || |(ehciWakeEvent & ehciWakeEnable);
    s_nxt.condPrev = wantLevel;
    if (wake || wantLevel != s_r.condPrev) begin
      s_nxt.level = clkrun_pkg::STOP_NONE;
    end else begin
      s_nxt.level = wantLevel;
    end
    // Decoded stop strobes registered so every output is a flop
    s_nxt.logicStop = s_nxt.level != clkrun_pkg::STOP_NONE;
    s_nxt.oscOff = s_nxt.level == clkrun_pkg::STOP_OSC;
    s_nxt.useOsc = extension_config_two[clkrun_pkg::CLK_SEL_BIT];

    // Link side: PCI clock and line are sampled only, never used as clocks
    s_nxt.clkSync = {s_r.clkSync[1:0], link.pciClk};
    s_nxt.lineSync = {s_r.lineSync[1:0], link.runLineIn};
    clkRise = s_r.clkSync[2:1] == 2'b01;
    lineHigh = s_r.lineSync[2] && s_r.lineSync[1];
    needClk = ohciBusMasterReq || ehci_run_stop_bit;
    s_nxt.held = needClk;
    case (s_r.state)
      IDLE: begin
        s_nxt.edgeCnt = 2'h0;
        if (clkRise) begin
          s_nxt.idleCnt = lineHigh ? ((s_r.idleCnt == 2'h3) ? 2'h3 : s_r.idleCnt + 2'h1) : 2'h0;
        end
        // Line may already be low from the central resource; then no drive needed
        if (needClk && lineHigh && s_r.idleCnt >= 2'(clkrun_pkg::IDLE_CLOCKS)) begin
          s_nxt.state = DRIVE;
          s_nxt.driveOe = 1'b1;
        end
      end
      DRIVE: begin
        if (clkRise) begin
          s_nxt.edgeCnt = s_r.edgeCnt + 2'h1;
          if (s_r.edgeCnt == 2'(clkrun_pkg::ASSERT_EDGES - 1)) begin
            s_nxt.driveOe = 1'b0;
            s_nxt.state = WAITRUN;
          end
        end
      end
      WAITRUN: begin
        // Central resource owns the line now; wait for its release
        s_nxt.idleCnt = 2'h0;
        if (lineHigh) begin
          s_nxt.state = IDLE;
        end
      end
      default: begin
        s_nxt.state = IDLE;
        s_nxt.driveOe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{clkSync: 3'h0, lineSync: 3'h7, auxSync: 3'h0, state: IDLE, edgeCnt: 2'h0,
               idleCnt: 2'h0, driveOe: 1'b0, useOsc: clkrun_pkg::CLK_SEL_RESET,
               level: clkrun_pkg::STOP_NONE, condPrev: clkrun_pkg::STOP_NONE, held: 1'b0,
               logicStop: 1'b0, oscOff: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.runLineDevOe = s_r.driveOe;
  assign useOscillator = s_r.useOsc;
  assign stopLevel = s_r.level;
  assign logicClkStop = s_r.logicStop;
  assign pllStop = s_r.level[1];
  assign oscStop = s_r.oscOff;
  assign pciClkHeld = s_r.held;
endmodule // usb_host_clock_gating_clkrun

// File: hdl/clkrun_pkg.sv
// Shared constants for the USB host clock gating and clock-run link.
// Assumes both ends run on clk_sys at 125 MHz; the link clock is sampled, not used as a clock.
// Functional notes
// - System clock from crystal or oscillator, selectable
// - External oscillator must run continuously when selected; oscStop here still asserts at STOP_OSC whatever useOscillator is
// - PCI clock domain kept separate from system
// - Three graded clock stop levels
// - Stop only when enhanced core halted
// - Stop only when all ports suspended/disabled
// - Stop only when open cores suspended/reset
// - Aux high, all D0: stop logic clocks
// - Aux high, none D0: stop logic and PLL
// - Aux low, none D0: stop oscillator output
// - Restart oscillator on condition change or activity
// - Enhanced-port wake events restart only when enabled
// - Keep PCI clock while open core masters
// - Keep PCI clock while run/stop set
// - Central resource runs clock four periods after release
// - Drive line low until two rising edges
// - Central resource drives low by third clock
// - Central resource holds low until fifth clock
// - Reassert after two deasserted clocks when needed
package clkrun_pkg;
  localparam int NUM_PORTS = 5;
  localparam int NUM_FUNCS = 3;
  localparam logic [1:0] FUNC_STATE_RESET = 2'h0;
  localparam logic [1:0] FUNC_STATE_SUSPEND = 2'h3;
  localparam logic [1:0] PWR_STATE_D0 = 2'h0;
  localparam int CLK_SEL_BIT = 6;
  localparam logic CLK_SEL_RESET = 1'h0;
  localparam int XTAL_MHZ = 30;
  localparam int OSC_MHZ = 48;
  localparam logic [1:0] STOP_NONE = 2'h0;
  localparam logic [1:0] STOP_LOGIC = 2'h1;
  localparam logic [1:0] STOP_PLL = 2'h2;
  localparam logic [1:0] STOP_OSC = 2'h3;
  localparam int ASSERT_EDGES = 2;
  localparam int IDLE_CLOCKS = 2;
  localparam int RUN_AFTER_RELEASE = 4;
  localparam int CR_ASSERT_LATEST = 3;
  localparam int CR_HOLD_EARLIEST = 5;
  localparam int CLK_SYS_MHZ = 125;
  localparam int PCI_HALF_NS = 60;
  localparam int PCI_HALF_CYC = (PCI_HALF_NS * CLK_SYS_MHZ + 999) / 1000;
endpackage

// File: hdl/clkrun_if.sv
// Clock-run line shared by the controller and the central resource.
// Assumes an open-drain wire with pull-up; level resolved from enables.
`timescale 1ns/1ps
interface clkrun_if;
  logic pciClk;
  logic runLineDevOe;
  logic runLineCrOe;
  logic runLineIn;
  assign runLineIn = !(runLineDevOe || runLineCrOe);
  modport device (input pciClk, input runLineIn, output runLineDevOe);
  modport central (output pciClk, input runLineIn, output runLineCrOe);
endinterface

// File: hdl/pci_clock_central.sv
// Central resource: makes the PCI clock and answers clock-run requests.
// Assumes the user side asks to stop the clock with stopReq.
`timescale 1ns/1ps
module pci_clock_central (
  input wire logic clk_sys,
  input wire logic nrst,
  clkrun_if.central link,
  input wire logic stopReq,
  output logic clockRunning
);
  typedef enum logic [1:0] {
    RUN = 2'h0,
    RELEASED = 2'h1,
    STOPPED = 2'h3,
    ANSWER = 2'h2
  } cr_state_t;

  typedef struct packed {
    logic [7:0] divCnt;
    logic pclk;
    logic [2:0] lineSync;
    cr_state_t state;
    logic [2:0] cnt;
    logic oe;
    logic running;
  } cr_t;

  cr_t s_r, s_nxt;
  logic rise;
  logic lineLow;

  always_comb begin
    s_nxt = s_r;
    rise = 1'b0;
    s_nxt.lineSync = {s_r.lineSync[1:0], link.runLineIn};
    lineLow = !s_r.lineSync[2] && !s_r.lineSync[1];
    if (s_r.running) begin
      if (s_r.divCnt == 8'(clkrun_pkg::PCI_HALF_CYC - 1)) begin
        s_nxt.divCnt = 8'h0;
        s_nxt.pclk = !s_r.pclk;
        rise = !s_r.pclk;
      end else begin
        s_nxt.divCnt = s_r.divCnt + 8'h1;
      end
    end
    case (s_r.state)
      RUN: begin
        s_nxt.oe = 1'b1;
        if (stopReq) begin
          s_nxt.oe = 1'b0;
          s_nxt.cnt = 3'h0;
          s_nxt.state = RELEASED;
        end
      end
      RELEASED: begin
        if (rise) begin
          s_nxt.cnt = s_r.cnt + 3'h1;
        end
        // Synchroniser still shows the old low just after release; wait two rises
        if (lineLow && s_r.cnt >= 3'(clkrun_pkg::IDLE_CLOCKS)) begin
          s_nxt.oe = 1'b1;
          s_nxt.cnt = 3'h0;
          s_nxt.state = ANSWER;
        end else if (s_r.cnt == 3'(clkrun_pkg::RUN_AFTER_RELEASE) && rise) begin
          // Stop in place of the next rise so four full periods have run
          s_nxt.running = 1'b0;
          s_nxt.pclk = 1'b0;
          s_nxt.divCnt = 8'h0;
          s_nxt.state = STOPPED;
        end
      end
      STOPPED: begin
        if (lineLow) begin
          s_nxt.running = 1'b1;
          s_nxt.oe = 1'b1;
          s_nxt.cnt = 3'h0;
          s_nxt.state = ANSWER;
        end
      end
      ANSWER: begin
        if (rise) begin
          s_nxt.cnt = s_r.cnt + 3'h1;
        end
        if (s_r.cnt == 3'(clkrun_pkg::CR_HOLD_EARLIEST)) begin
          s_nxt.state = RUN;
        end
      end
      default: begin
        s_nxt.state = RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_r <= '{divCnt: 8'h0, pclk: 1'b0, lineSync: 3'h0, state: RUN, cnt: 3'h0,
               oe: 1'b1, running: 1'b1};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.pciClk = s_r.pclk;
  assign link.runLineCrOe = s_r.oe;
  assign clockRunning = s_r.running;
endmodule // pci_clock_central

// File: verification/clkrun_props.sv
// Checker for the clock-run line joining the controller and the central resource.
// Assumes the interface signals, sampled on clk_sys; no bind, instantiated in tb_top.
`timescale 1ns/1ps
module clkrun_props (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic pciClk,
  input wire logic runLineDevOe,
  input wire logic runLineCrOe,
  input wire logic runLineIn
);
  logic pciPrev;
  logic pciRise;
  logic [2:0] devRises, crRises, relRises;
  logic [3:0] lowCnt;
  assign pciRise = pciClk && !pciPrev;
  // Saturating rise counts; saturation keeps idle periods from wrapping
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pciPrev <= 1'b0;
      devRises <= 3'h0;
      crRises <= 3'h7;
      relRises <= 3'h0;
      lowCnt <= 4'h0;
    end else begin
      pciPrev <= pciClk;
      if (!runLineDevOe)
        devRises <= 3'h0;
      else if (pciRise && devRises != 3'h7)
        devRises <= devRises + 3'h1;
      if (runLineDevOe && devRises == 3'h0 && !pciRise)
        crRises <= 3'h0;
      else if (pciRise && crRises != 3'h7)
        crRises <= crRises + 3'h1;
      if (!runLineIn)
        relRises <= 3'h0;
      else if (pciRise && relRises != 3'h7)
        relRises <= relRises + 3'h1;
      if (pciClk)
        lowCnt <= 4'h0;
      else if (lowCnt != 4'hf)
        lowCnt <= lowCnt + 4'h1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  dev_hold_a: assert property (runLineDevOe |-> devRises <= 3'h2)
    else $error("clock-run drive held past two link clock rises");
  dev_release_a: assert property ($fell(runLineDevOe) |-> devRises >= 3'h2)
    else $error("clock-run drive released before two rises");
  dev_idle_a: assert property ($rose(runLineDevOe) |-> relRises >= 3'h2)
    else $error("clock-run asserted without two idle clocks");
  cr_answer_a: assert property ($rose(runLineDevOe) |-> ##[1:48] runLineCrOe)
    else $error("central resource did not join the request in time");
  cr_restart_a: assert property (lowCnt == 4'hf && !runLineIn |-> ##[1:40] pciClk)
    else $error("stopped link clock not restarted on request");
  cr_hold_a: assert property ($fell(runLineCrOe) |-> crRises >= 3'h5)
    else $error("central resource released before fifth clock");
  stop_after_a: assert property (lowCnt == 4'h9 |-> relRises >= 3'h4)
    else $error("link clock stopped within four periods of release");
  stop_quiet_a: assert property (lowCnt == 4'h9 |-> !runLineCrOe)
    else $error("link clock stopped while central drives the line");
endmodule // clkrun_props

// File: verification/tb_top.sv
// Testbench joining the clock gating controller and the central resource.
// Assumes the design files and clkrun_pkg are compiled first.
`timescale 1ns/1ps
module tb_top;
  logic clk_sys, nrst, ehci_stopped_flag, aux_power_reset_input, ohciActivity;
  logic ohciBusMasterReq, ehci_run_stop_bit, stopReq, useOscillator, logicClkStop;
  logic pllStop, oscStop, pciClkHeld, clockRunning;
  logic [7:0] extension_config_two;
  logic [clkrun_pkg::NUM_PORTS-1:0] portSuspended, portEnabled;
  logic [1:0] ohci_functional_state_a, ohci_functional_state_b, stopLevel;
  logic [5:0] funcPowerState;
  logic [2:0] ehciWakeEvent, ehciWakeEnable;
  int fail_count = 0;
  int check_count = 0;
  clkrun_if link ();
  usb_host_clock_gating_clkrun u_usb_host_clock_gating_clkrun (.clk_sys, .nrst, .link,
    .extension_config_two, .ehci_stopped_flag, .portSuspended, .portEnabled,
    .ohci_functional_state_a, .ohci_functional_state_b, .aux_power_reset_input,
    .funcPowerState, .ohciActivity, .ehciWakeEvent, .ehciWakeEnable, .ohciBusMasterReq,
    .ehci_run_stop_bit, .useOscillator, .stopLevel, .logicClkStop, .pllStop, .oscStop,
    .pciClkHeld);
  pci_clock_central u_pci_clock_central (.clk_sys, .nrst, .link, .stopReq, .clockRunning);
  clkrun_props u_clkrun_props (.clk_sys, .nrst, .pciClk(link.pciClk),
    .runLineDevOe(link.runLineDevOe), .runLineCrOe(link.runLineCrOe),
    .runLineIn(link.runLineIn));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Generous settle: aux synchroniser plus two-cycle stability filter
  task automatic level(input logic h, input logic [4:0] en, input logic [1:0] fb,
      input logic aux, input logic [5:0] pwr, input logic [1:0] exp);
    @(posedge clk_sys);
    ehci_stopped_flag <= h;
    portEnabled <= en;
    ohci_functional_state_b <= fb;
    aux_power_reset_input <= aux;
    funcPowerState <= pwr;
    repeat (12) @(posedge clk_sys);
    #1;
    check("stopLevel", stopLevel, exp);
    check("logicClkStop", logicClkStop, exp != clkrun_pkg::STOP_NONE);
    check("pllStop", pllStop, exp[1]);
    check("oscStop", oscStop, exp == clkrun_pkg::STOP_OSC);
  endtask
  // One-cycle wake pulse; level must drop at the very next edge
  task automatic wake(input logic act, input logic [2:0] ev, input logic [2:0] en,
      input logic [1:0] exp);
    @(posedge clk_sys);
    ohciActivity <= act;
    ehciWakeEvent <= ev;
    ehciWakeEnable <= en;
    @(posedge clk_sys);
    ohciActivity <= 1'b0;
    ehciWakeEvent <= 3'h0;
    #1;
    check("wakeLevel", stopLevel, exp);
    repeat (12) @(posedge clk_sys);
  endtask
  task automatic waitRun(input logic v);
    int n;
    n = 0;
    while (clockRunning !== v && n < 600) begin
      @(posedge clk_sys);
      n++;
    end
    #1;
    check("clockRunning", clockRunning, v);
  endtask
  initial begin
    {nrst, ehci_stopped_flag, aux_power_reset_input, ohciActivity, ohciBusMasterReq,
      ehci_run_stop_bit, stopReq, extension_config_two, portEnabled, funcPowerState,
      ehciWakeEvent, ehciWakeEnable, ohci_functional_state_b} = '0;
    portSuspended = 5'h01;
    ohci_functional_state_a = clkrun_pkg::FUNC_STATE_RESET;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      extension_config_two <= i ? 8'hbf : 8'h40;
      repeat (3) @(posedge clk_sys);
      #1;
      check("useOscillator", useOscillator, i == 0);
    end
    $display("test clock select done");
    level(1, 5'h01, clkrun_pkg::FUNC_STATE_SUSPEND, 1, 6'h00, clkrun_pkg::STOP_LOGIC);
    level(1, 5'h01, clkrun_pkg::FUNC_STATE_SUSPEND, 1, 6'h3f, clkrun_pkg::STOP_PLL);
    level(1, 5'h01, clkrun_pkg::FUNC_STATE_SUSPEND, 0, 6'h3f, clkrun_pkg::STOP_OSC);
    wake(1, 3'h0, 3'h0, clkrun_pkg::STOP_NONE);
    for (int i = 0; i < 3; i++) begin
      wake(0, 3'h1 << i, 3'h0, clkrun_pkg::STOP_OSC);
      wake(0, 3'h1 << i, 3'h1 << i, clkrun_pkg::STOP_NONE);
    end
    $display("test wake done");
    level(1, 5'h01, clkrun_pkg::FUNC_STATE_SUSPEND, 0, 6'h00, clkrun_pkg::STOP_NONE);
    level(1, 5'h01, clkrun_pkg::FUNC_STATE_SUSPEND, 1, 6'h0c, clkrun_pkg::STOP_NONE);
    level(0, 5'h01, clkrun_pkg::FUNC_STATE_SUSPEND, 1, 6'h3f, clkrun_pkg::STOP_NONE);
    level(1, 5'h03, clkrun_pkg::FUNC_STATE_SUSPEND, 1, 6'h3f, clkrun_pkg::STOP_NONE);
    level(1, 5'h01, 2'h2, 1, 6'h3f, clkrun_pkg::STOP_NONE);
    level(1, 5'h01, clkrun_pkg::FUNC_STATE_RESET, 1, 6'h3f, clkrun_pkg::STOP_PLL);
    $display("test stop levels done");
    @(posedge clk_sys);
    stopReq <= 1'b1;
    waitRun(1'b0);
    check("lineIdle", link.runLineIn, 1'b1);
    @(posedge clk_sys);
    ohciBusMasterReq <= 1'b1;
    waitRun(1'b1);
    check("pciClkHeld", pciClkHeld, 1'b1);
    @(posedge clk_sys);
    ohciBusMasterReq <= 1'b0;
    waitRun(1'b0);
    @(posedge clk_sys);
    ehci_run_stop_bit <= 1'b1;
    waitRun(1'b1);
    // Central keeps releasing; only reassertion keeps the clock alive
    repeat (300) @(posedge clk_sys);
    #1;
    check("clockHeld", clockRunning, 1'b1);
    @(posedge clk_sys);
    ehci_run_stop_bit <= 1'b0;
    waitRun(1'b0);
    $display("test clock run done");
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    results();
  end
endmodule // tb_top
